/* File: lai_line_alarm_interrupt_latch.sv */
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module lai_line_alarm_interrupt_latch (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       ce,
    input  wire logic [lai_pkg::ADDR_W-1:0] addr,
    input  wire logic [lai_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    input  wire logic [lai_pkg::NUM_CH-1:0] sys_alarm_state,
    input  wire logic [lai_pkg::NUM_CH-1:0] line_alarm_state,
    input  wire logic [lai_pkg::NUM_CH-1:0] pattern_sync_state,
    input  wire logic [lai_pkg::NUM_CH-1:0] loop_up_code_state,
    input  wire logic [lai_pkg::NUM_CH-1:0] loop_down_code_state,
    input  wire logic [lai_pkg::NUM_CH-1:0] sys_bipolar_violation_evt,
    input  wire logic [lai_pkg::NUM_CH-1:0] line_bipolar_violation_evt,
    input  wire logic [lai_pkg::NUM_CH-1:0] sys_excess_zero_evt,
    input  wire logic [lai_pkg::NUM_CH-1:0] line_excess_zero_evt,
    input  wire logic [lai_pkg::NUM_CH-1:0] pattern_error_evt,
    input  wire logic [lai_pkg::NUM_CH-1:0] err_counter_overflow_evt,
    output logic      [lai_pkg::DATA_W-1:0] rdata,
    output logic                            irq_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0] st1_q   [lai_pkg::NUM_CH];   // Alarm and code sticky status
    logic [7:0] st1_d   [lai_pkg::NUM_CH];
    logic [7:0] st2_q   [lai_pkg::NUM_CH];   // Error event sticky status
    logic [7:0] st2_d   [lai_pkg::NUM_CH];
    logic [7:0] mask1_q [lai_pkg::NUM_CH];   // Mask for first status register
    logic [7:0] mask1_d [lai_pkg::NUM_CH];
    logic [7:0] mask2_q [lai_pkg::NUM_CH];   // Mask for second status register
    logic [7:0] mask2_d [lai_pkg::NUM_CH];
    logic [7:0] es_q    [lai_pkg::NUM_CH];   // Edge select per channel
    logic [7:0] es_d    [lai_pkg::NUM_CH];
    logic [4:0] prev_q  [lai_pkg::NUM_CH];   // Last sampled live state
    logic [4:0] prev_d  [lai_pkg::NUM_CH];
    logic [7:0] rdata_q;                     // Read data, valid one cycle
    logic [7:0] rdata_d;
    logic       irq_n_q;                     // Registered interrupt pin
    logic       irq_n_d;

    logic       hit;                         // Address falls in a channel block
    logic [3:0] hit_ch;                      // Channel addressed
    logic [5:0] hit_off;                     // Offset inside the block

    ////////////////////////////////////////////////////////////////////////////
    // Address decode: channels 1 to 8 in blocks 0 to 7, channel 0 in top block
    always_comb begin
        hit     = 1'b0;
        hit_ch  = 4'h0;
        hit_off = addr[5:0];
        if (addr[10:6] == lai_pkg::CH0_BLOCK) begin
            hit    = 1'b1;
            hit_ch = 4'h0;
        end else if (addr[10:6] <= lai_pkg::LAST_BLOCK) begin
            hit    = 1'b1;
            hit_ch = 4'(addr[9:6]) + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state of every channel's registers
    always_comb begin
        logic [4:0] cur;
        logic [4:0] sel;
        logic [4:0] set5;
        logic [7:0] set1;
        logic [7:0] set2;
        logic [7:0] clr1;
        logic [7:0] clr2;
        logic       sel_ch;
        cur    = 5'h00;
        sel    = 5'h00;
        set5   = 5'h00;
        set1   = 8'h00;
        set2   = 8'h00;
        clr1   = 8'h00;
        clr2   = 8'h00;
        sel_ch = 1'b0;
        for (int c = 0; c < lai_pkg::NUM_CH; c++) begin
            // Live state in the layout of the first status register, packed
            cur = {sys_alarm_state[c], line_alarm_state[c], pattern_sync_state[c],
                   loop_up_code_state[c], loop_down_code_state[c]};
            // Both alarms share one select, both loop codes share another
            sel = {es_q[c][lai_pkg::B_ES_ALARM], es_q[c][lai_pkg::B_ES_ALARM],
                   es_q[c][lai_pkg::B_ES_SYNC], es_q[c][lai_pkg::B_ES_LOOP],
                   es_q[c][lai_pkg::B_ES_LOOP]};
            // Select 1 takes any change, select 0 rising only
            set5 = (sel & (cur ^ prev_q[c])) | (~sel & cur & ~prev_q[c]);
            set1 = 8'h00;
            set1[lai_pkg::B_SYS_ALARM]  = set5[4];
            set1[lai_pkg::B_LINE_ALARM] = set5[3];
            set1[lai_pkg::B_PAT_SYNC]   = set5[2];
            set1[lai_pkg::B_LOOP_UP]    = set5[1];
            set1[lai_pkg::B_LOOP_DOWN]  = set5[0];
            set2 = 8'h00;
            set2[lai_pkg::B_SYS_BPV]  = sys_bipolar_violation_evt[c];
            set2[lai_pkg::B_LINE_BPV] = line_bipolar_violation_evt[c];
            set2[lai_pkg::B_SYS_EXZ]  = sys_excess_zero_evt[c];
            set2[lai_pkg::B_LINE_EXZ] = line_excess_zero_evt[c];
            set2[lai_pkg::B_PAT_ERR]  = pattern_error_evt[c];
            set2[lai_pkg::B_CNT_OVF]  = err_counter_overflow_evt[c];
            // Write strobe aimed at this channel
            sel_ch = wr && hit && (hit_ch == 4'(c));
            clr1 = (sel_ch && hit_off == lai_pkg::OFF_ST1) ? wdata : 8'h00;
            clr2 = (sel_ch && hit_off == lai_pkg::OFF_ST2) ? wdata : 8'h00;
            // A new event in the clearing cycle wins over the clear
            st1_d[c] = ((st1_q[c] & ~clr1) | set1) & lai_pkg::VALID1;
            st2_d[c] = ((st2_q[c] & ~clr2) | set2) & lai_pkg::VALID2;
            // Plain read/write configuration registers
            mask1_d[c] = (sel_ch && hit_off == lai_pkg::OFF_MASK1)
                       ? (wdata & lai_pkg::VALID1) : mask1_q[c];
            mask2_d[c] = (sel_ch && hit_off == lai_pkg::OFF_MASK2)
                       ? (wdata & lai_pkg::VALID2) : mask2_q[c];
            es_d[c]    = (sel_ch && hit_off == lai_pkg::OFF_EDGE_SEL)
                       ? (wdata & lai_pkg::VALID_ES) : es_q[c];
            prev_d[c]  = cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and interrupt pin
    always_comb begin
        logic [7:0] state1;
        logic       pend;
        state1  = 8'h00;
        pend    = 1'b0;
        rdata_d = 8'h00;
        // Live state of the addressed channel, in status layout
        state1[lai_pkg::B_SYS_ALARM]  = sys_alarm_state[hit_ch];
        state1[lai_pkg::B_LINE_ALARM] = line_alarm_state[hit_ch];
        state1[lai_pkg::B_PAT_SYNC]   = pattern_sync_state[hit_ch];
        state1[lai_pkg::B_LOOP_UP]    = loop_up_code_state[hit_ch];
        state1[lai_pkg::B_LOOP_DOWN]  = loop_down_code_state[hit_ch];
        if (rd && hit) begin
            case (hit_off)
                lai_pkg::OFF_ST1:      rdata_d = st1_q[hit_ch];
                lai_pkg::OFF_ST2:      rdata_d = st2_q[hit_ch];
                lai_pkg::OFF_MASK1:    rdata_d = mask1_q[hit_ch];
                lai_pkg::OFF_MASK2:    rdata_d = mask2_q[hit_ch];
                lai_pkg::OFF_EDGE_SEL: rdata_d = es_q[hit_ch];
                lai_pkg::OFF_STATE1:   rdata_d = state1;
                // Unmapped offsets read as zero
                default:               rdata_d = 8'h00;
            endcase
        end
        // Unmasked pending bits of all channels, from next values
        for (int c = 0; c < lai_pkg::NUM_CH; c++) begin
            pend = pend | (|(st1_d[c] & ~mask1_d[c])) | (|(st2_d[c] & ~mask2_d[c]));
        end
        irq_n_d = ~pend;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; clock enable low freezes everything
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < lai_pkg::NUM_CH; c++) begin
                st1_q[c]   <= lai_pkg::RST_ST;
                st2_q[c]   <= lai_pkg::RST_ST;
                mask1_q[c] <= lai_pkg::RST_MASK1;
                mask2_q[c] <= lai_pkg::RST_MASK2;
                es_q[c]    <= lai_pkg::RST_ES;
                prev_q[c]  <= lai_pkg::RST_PREV;
            end
            rdata_q <= 8'h00;
            irq_n_q <= 1'b1;
        end else if (ce) begin
            for (int c = 0; c < lai_pkg::NUM_CH; c++) begin
                st1_q[c]   <= st1_d[c];
                st2_q[c]   <= st2_d[c];
                mask1_q[c] <= mask1_d[c];
                mask2_q[c] <= mask2_d[c];
                es_q[c]    <= es_d[c];
                prev_q[c]  <= prev_d[c];
            end
            rdata_q <= rdata_d;
            irq_n_q <= irq_n_d;
        end
    end

    assign rdata = rdata_q;
    assign irq_n = irq_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on channel 0 and channel 1, and of the pin against all channels
    logic wr_st1_ch0;   // Write to channel 0 first status register
    assign wr_st1_ch0 = wr && addr == {lai_pkg::CH0_BLOCK, lai_pkg::OFF_ST1};

    property p_sys_rise;
        @(posedge clk) disable iff (reset)
        ce && !prev_q[0][4] && sys_alarm_state[0] |=> st1_q[0][7];
    endproperty
    a_sys_rise: assert property (p_sys_rise) else $error("System alarm rise lost");

    property p_sys_fall;
        @(posedge clk) disable iff (reset)
        ce && es_q[0][6] && prev_q[0][4] && !sys_alarm_state[0] |=> st1_q[0][7];
    endproperty
    a_sys_fall: assert property (p_sys_fall) else $error("System alarm fall lost");

    property p_line_fall_ignored;
        @(posedge clk) disable iff (reset)
        ce && !es_q[0][6] && !st1_q[0][6] && prev_q[0][3] && !line_alarm_state[0]
        |=> !st1_q[0][6];
    endproperty
    a_line_fall_ignored: assert property (p_line_fall_ignored)
        else $error("Line alarm fall set bit with rising select");

    property p_sync_rise;
        @(posedge clk) disable iff (reset)
        ce && !prev_q[0][2] && pattern_sync_state[0] |=> st1_q[0][5];
    endproperty
    a_sync_rise: assert property (p_sync_rise) else $error("Pattern sync rise lost");

    property p_up_rise;
        @(posedge clk) disable iff (reset)
        ce && !prev_q[0][1] && loop_up_code_state[0] |=> st1_q[0][1];
    endproperty
    a_up_rise: assert property (p_up_rise) else $error("Loop-up rise lost");

    property p_down_fall;
        @(posedge clk) disable iff (reset)
        ce && es_q[0][0] && prev_q[0][0] && !loop_down_code_state[0] |=> st1_q[0][0];
    endproperty
    a_down_fall: assert property (p_down_fall) else $error("Loop-down fall lost");

    property p_w1c;
        @(posedge clk) disable iff (reset)
        ce && wr_st1_ch0 && wdata[7] && (sys_alarm_state[0] == prev_q[0][4])
        |=> !st1_q[0][7];
    endproperty
    a_w1c: assert property (p_w1c) else $error("Write one did not clear");

    property p_hold;
        @(posedge clk) disable iff (reset)
        st1_q[0][7] && !(ce && wr_st1_ch0 && wdata[7]) |=> st1_q[0][7];
    endproperty
    a_hold: assert property (p_hold) else $error("Sticky bit dropped");

    property p_irq;
        @(posedge clk) disable iff (reset)
        ce && (st1_d[0] & ~mask1_d[0]) != 8'h00 |=> !irq_n;
    endproperty
    a_irq: assert property (p_irq) else $error("Pending bit not on pin");

    // Any unmasked set bit in any channel, from the registered values
    logic open_any;
    always_comb begin
        open_any = 1'b0;
        for (int c = 0; c < lai_pkg::NUM_CH; c++) begin
            open_any = open_any | (|(st1_q[c] & ~mask1_q[c])) | (|(st2_q[c] & ~mask2_q[c]));
        end
    end

    // Masked bits may latch but never pull the pin; unmasked ones always do
    property p_masked;
        @(posedge clk) disable iff (reset)
        ce |=> irq_n == !open_any;
    endproperty
    a_masked: assert property (p_masked) else $error("Masked bit leaked");

    property p_ovf;
        @(posedge clk) disable iff (reset)
        ce && err_counter_overflow_evt[0] |=> st2_q[0][0];
    endproperty
    a_ovf: assert property (p_ovf) else $error("Counter overflow lost");

    property p_bpv;
        @(posedge clk) disable iff (reset)
        ce && sys_bipolar_violation_evt[1] |=> st2_q[1][5];
    endproperty
    a_bpv: assert property (p_bpv) else $error("Bipolar violation lost");

    property p_read_ch1;
        @(posedge clk) disable iff (reset)
        ce && rd && addr == 11'h022 |=> rdata == $past(st2_q[1]);
    endproperty
    a_read_ch1: assert property (p_read_ch1) else $error("Channel 1 read wrong");

    c_irq:   cover property (@(posedge clk) disable iff (reset) $fell(irq_n));
    c_clear: cover property (@(posedge clk) disable iff (reset) st1_q[0][7] ##1 !st1_q[0][7]);
    c_fall:  cover property (@(posedge clk) disable iff (reset) es_q[0][6] && $fell(sys_alarm_state[0]));

endmodule : lai_line_alarm_interrupt_latch

`default_nettype wire

/* File: lai_pkg.sv */
////////////////////////////////////////////////////////////////////////////////
// Shared constants for the line alarm interrupt latch
package lai_pkg;

    // Channel geometry
    localparam int          NUM_CH       = 9;          // Channel 0 plus channels 1 to 8
    localparam int          ADDR_W       = 11;         // Register address width
    localparam int          DATA_W       = 8;          // Register data width
    localparam logic [4:0]  CH0_BLOCK    = 5'h1f;      // Address block of channel 0
    localparam logic [4:0]  LAST_BLOCK   = 5'h07;      // Last block of channels 1 to 8

    // Register offsets inside one channel block
    localparam logic [5:0]  OFF_EDGE_SEL = 6'h1b;      // edge_select_reg
    localparam logic [5:0]  OFF_MASK1    = 6'h1c;      // Mask for alarm and code status
    localparam logic [5:0]  OFF_MASK2    = 6'h1d;      // Mask for error event status
    localparam logic [5:0]  OFF_STATE1   = 6'h1f;      // Live alarm and code state
    localparam logic [5:0]  OFF_ST1      = 6'h21;      // alarm_code_interrupt_status
    localparam logic [5:0]  OFF_ST2      = 6'h22;      // error_event_interrupt_status

    // Bit positions of the first status register and live state register
    localparam int          B_SYS_ALARM  = 7;
    localparam int          B_LINE_ALARM = 6;
    localparam int          B_PAT_SYNC   = 5;
    localparam int          B_LOOP_UP    = 1;
    localparam int          B_LOOP_DOWN  = 0;

    // Bit positions of the second status register
    localparam int          B_SYS_BPV    = 5;
    localparam int          B_LINE_BPV   = 4;
    localparam int          B_SYS_EXZ    = 3;
    localparam int          B_LINE_EXZ   = 2;
    localparam int          B_PAT_ERR    = 1;
    localparam int          B_CNT_OVF    = 0;

    // Edge select bit positions
    localparam int          B_ES_ALARM   = 6;
    localparam int          B_ES_SYNC    = 5;
    localparam int          B_ES_LOOP    = 0;

    // Implemented bits of each register
    localparam logic [7:0]  VALID1       = 8'he3;
    localparam logic [7:0]  VALID2       = 8'h3f;
    localparam logic [7:0]  VALID_ES     = 8'h61;

    // Reset values
    localparam logic [7:0]  RST_ST       = 8'h00;
    localparam logic [7:0]  RST_MASK1    = 8'he3;
    localparam logic [7:0]  RST_MASK2    = 8'h3f;
    localparam logic [7:0]  RST_ES       = 8'h00;
    localparam logic [4:0]  RST_PREV     = 5'h00;

endpackage : lai_pkg

/* File: line_alarm_interrupt_latch_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module line_alarm_interrupt_latch_bench;

    logic                       clk;                // Bench clock, 200 MHz
    logic                       reset;              // Asynchronous reset, active high
    logic                       ce;                 // Clock enable, high except in the last test
    logic [10:0]                addr;               // Register address
    logic [7:0]                 wdata;              // Register write data
    logic                       wr;                 // Write strobe
    logic                       rd;                 // Read strobe
    logic                       rd_q;               // Read taken at the last edge
    logic [7:0]                 rdata;              // Read data from the block
    logic                       irq_n;              // Interrupt pin, active low
    logic [lai_pkg::NUM_CH-1:0] st [5];             // Live state levels per source
    logic [lai_pkg::NUM_CH-1:0] evt [6];            // Event pulses per source
    logic [7:0]                 exp_q [$];          // Expected read data, oldest first
    int                         fails;              // Mismatch count
    int                         compares;           // Comparison count
    int                         st_pos [5] = '{7, 6, 5, 1, 0};    // Status bit per state source
    int                         es_pos [5] = '{6, 6, 5, 0, 0};    // Edge select bit per source
    int                         ev_pos [6] = '{5, 4, 3, 2, 1, 0}; // Status bit per event source

    ////////////////////////////////////////////////////////////////////////////
    // Device under test
    lai_line_alarm_interrupt_latch DUT (
        .clk                        (clk),
        .reset                      (reset),
        .ce                         (ce),
        .addr                       (addr),
        .wdata                      (wdata),
        .wr                         (wr),
        .rd                         (rd),
        .sys_alarm_state            (st[0]),
        .line_alarm_state           (st[1]),
        .pattern_sync_state         (st[2]),
        .loop_up_code_state         (st[3]),
        .loop_down_code_state       (st[4]),
        .sys_bipolar_violation_evt  (evt[0]),
        .line_bipolar_violation_evt (evt[1]),
        .sys_excess_zero_evt        (evt[2]),
        .line_excess_zero_evt       (evt[3]),
        .pattern_error_evt          (evt[4]),
        .err_counter_overflow_evt   (evt[5]),
        .rdata                      (rdata),
        .irq_n                      (irq_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    // Channel block base: channel 0 sits at the top block
    function automatic logic [10:0] base(input int c);
        base = (c == 0) ? 11'h7c0 : 11'((c - 1) * 64);
    endfunction : base

    // One-hot byte
    function automatic logic [7:0] bit8(input int b);
        bit8 = 8'h01 << b;
    endfunction : bit8

    // Compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Single-cycle register write
    task automatic wr_reg(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Single-cycle register read; the monitor compares the answer
    task automatic rd_reg(input logic [10:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(exp);
        @(posedge clk);
        rd   <= 1'b0;
    endtask : rd_reg

    // Let some edges pass
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    // Interrupt pin check mid-cycle, then back on the rising edge for stimulus
    task automatic irq_chk(input logic e);
        @(negedge clk);
        check("irq_n", {7'h00, irq_n}, {7'h00, e});
        @(posedge clk);
    endtask : irq_chk

    // Verdict and end of run
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////
    // Read monitor: data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rd_q <= rd & ce;
    end

    always @(negedge clk) begin
        if (rd_q) begin
            check("rdata", rdata, exp_q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #50000;
        fails++;
        $display("[FAIL] watchdog expected done seen timeout");
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int c;
        int c2;
        int s;
        logic [10:0] a;
        clk = 0;
        reset = 1;
        ce = 1;
        wr = 0;
        rd = 0;
        addr = '0;
        wdata = '0;
        fails = 0;
        compares = 0;
        foreach (st[i]) st[i] = '0;
        foreach (evt[i]) evt[i] = '0;
        void'($urandom(32'h866d));
        step(4);
        reset <= 1'b0;
        // Status reset values on every channel copy, mask reset values on channel 0
        for (int i = 0; i < 9; i++) begin
            rd_reg(base(i) + 11'h021, 8'h00);
            rd_reg(base(i) + 11'h022, 8'h00);
        end
        rd_reg(base(0) + 11'h01c, 8'he3);
        rd_reg(base(0) + 11'h01d, 8'h3f);
        irq_chk(1'b1);
        // Unmapped block reads zero and ignores writes
        wr_reg(11'h301, 8'hff);
        rd_reg(11'h301, 8'h00);
        // Edge capture of each state source, rising then any change
        // First pass on channel 0, where the assertions watch, then random channels
        for (int k = 0; k < 10; k++) begin
            s = k % 5;
            c = (k < 5) ? 0 : $urandom_range(8);
            a = base(c);
            wr_reg(a + 11'h01c, 8'h00);
            wr_reg(a + 11'h01b, 8'h00);
            st[s][c] <= 1'b1;
            step(2);
            irq_chk(1'b0);
            rd_reg(a + 11'h01f, bit8(st_pos[s]));
            rd_reg(a + 11'h021, bit8(st_pos[s]));
            wr_reg(a + 11'h021, 8'($urandom) & ~bit8(st_pos[s]));
            rd_reg(a + 11'h021, bit8(st_pos[s]));
            wr_reg(a + 11'h021, bit8(st_pos[s]));
            rd_reg(a + 11'h021, 8'h00);
            irq_chk(1'b1);
            st[s][c] <= 1'b0;
            step(2);
            rd_reg(a + 11'h021, 8'h00);
            wr_reg(a + 11'h01b, bit8(es_pos[s]));
            st[s][c] <= 1'b1;
            step(2);
            wr_reg(a + 11'h021, bit8(st_pos[s]));
            st[s][c] <= 1'b0;
            step(2);
            rd_reg(a + 11'h021, bit8(st_pos[s]));
            wr_reg(a + 11'h021, bit8(st_pos[s]));
            rd_reg(a + 11'h021, 8'h00);
        end
        // Error events, masking and clearing
        for (s = 0; s < 6; s++) begin
            // Channel 1 for system bipolar violation, channel 0 for overflow
            c = (s == 0) ? 1 : (s == 5) ? 0 : $urandom_range(8);
            a = base(c);
            wr_reg(a + 11'h01d, 8'h00);
            @(posedge clk);
            evt[s][c] <= 1'b1;
            @(posedge clk);
            evt[s][c] <= 1'b0;
            step(1);
            irq_chk(1'b0);
            rd_reg(a + 11'h022, bit8(ev_pos[s]));
            wr_reg(a + 11'h01d, 8'h3f);
            irq_chk(1'b1);
            rd_reg(a + 11'h022, bit8(ev_pos[s]));
            wr_reg(a + 11'h022, bit8(ev_pos[s]));
            rd_reg(a + 11'h022, 8'h00);
        end
        // Two channels pending: pin stays low until both are cleared
        c  = 0;
        c2 = 8;
        wr_reg(base(c) + 11'h01d, 8'h00);
        wr_reg(base(c2) + 11'h01d, 8'h00);
        @(posedge clk);
        evt[4][c]  <= 1'b1;
        evt[4][c2] <= 1'b1;
        @(posedge clk);
        evt[4] <= '0;
        step(1);
        wr_reg(base(c) + 11'h022, 8'h02);
        irq_chk(1'b0);
        wr_reg(base(c2) + 11'h022, 8'h02);
        irq_chk(1'b1);
        // Clock enable low: a write and an event are both ignored
        ce <= 1'b0;
        wr_reg(base(2) + 11'h01d, 8'h00);
        evt[5][2] <= 1'b1;
        step(1);
        evt[5][2] <= 1'b0;
        ce        <= 1'b1;
        rd_reg(base(2) + 11'h022, 8'h00);
        rd_reg(base(2) + 11'h01d, 8'h3f);
        step(3);
        check("pending reads", 8'(exp_q.size()), 8'h00);
        give_verdict();
    end

endmodule : line_alarm_interrupt_latch_bench

`default_nettype wire
